// file: pos_rx_pkg.sv
/*
  Holds the shared constants of the packet receive link: widths, FIFO depth,
  clock rates, link clock divider and the word layout kept in the FIFO.
  Assumes both ends are clocked by ref_clk at 200 MHz and reset by rstn.
*/
// Functional notes
// - valid strobe qualifies data, start, end, error, pad
// - parity holds meaning whatever the valid strobe
// - valid strobe tristated outside packet mode
// - valid strobe enabled exactly like data bus
// - config zero: valid follows FIFO occupancy only
// - read of empty FIFO drops valid strobe
// - read of empty FIFO leaves FIFO untouched
// - host ignores outputs other than end flag while valid is low
// - underflow raises no error, nothing counted
// - config one: pause after last word of packet
// - host tells pause from empty by end flag
// - after pause host drops read enable, reselects; host here only drops read enable, it has no port select
// - after empty host may keep read enable
// - reading resumes once FIFO holds new data
// - valid strobe changes only at link rising edge
// - end flag marks final word of each packet
// - error flag only with end flag on final word
// - pad count zero unless end flag high
package pos_rx_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int DATA_W     = 32;
  localparam int PAD_W      = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int PTR_W      = 2;

  // word layout inside the FIFO: {err, eop, sop, pad, data}
  localparam int DATA_LSB = 0;
  localparam int PAD_LSB  = DATA_W;
  localparam int SOP_BIT  = DATA_W + PAD_W;
  localparam int EOP_BIT  = SOP_BIT + 1;
  localparam int ERR_BIT  = EOP_BIT + 1;
  localparam int WORD_W   = ERR_BIT + 1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int REF_PERIOD_NS  = 5;
  localparam int LINK_HALF_NS   = 80;
  localparam int LINK_HALF_CYC  = (LINK_HALF_NS / REF_PERIOD_NS < 1) ? 1 : LINK_HALF_NS / REF_PERIOD_NS;
  localparam int DIV_W          = 5;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [PAD_W-1:0]  PAD_ZERO = 3'h0;

endpackage

// file: pos_rx_if.sv
/*
  Holds the link between the receive device end and the link layer end.
  Assumes the link layer end makes the interface clock; every tristatable
  output of the device comes with one shared enable, high while driven.
*/
interface pos_rx_if;
  import pos_rx_pkg::*;

  logic              rx_interface_clock;
  logic              rx_read_enable;
  logic [DATA_W-1:0] rx_word_bus;
  logic              rx_word_valid;
  logic              rx_start_of_packet;
  logic              rx_end_of_packet;
  logic              rx_packet_error;
  logic [PAD_W-1:0]  rx_pad_byte_count;
  logic              rx_word_parity;
  logic              rx_drive_oe;

  modport device_mp (
    input  rx_interface_clock,
    input  rx_read_enable,
    output rx_word_bus,
    output rx_word_valid,
    output rx_start_of_packet,
    output rx_end_of_packet,
    output rx_packet_error,
    output rx_pad_byte_count,
    output rx_word_parity,
    output rx_drive_oe
  );

  modport host_mp (
    output rx_interface_clock,
    output rx_read_enable,
    input  rx_word_bus,
    input  rx_word_valid,
    input  rx_start_of_packet,
    input  rx_end_of_packet,
    input  rx_packet_error,
    input  rx_pad_byte_count,
    input  rx_word_parity,
    input  rx_drive_oe
  );
endinterface

// file: pos_rx_device.sv
/*
  Holds the device end: a small receive FIFO and the logic that presents
  its words on the link with the valid strobe and packet flags.
  Assumes the link clock arrives from the far end and is sampled by ref_clk;
  the far end changes read enable away from the link rising edge.
*/

// ---------------------------------------------------------------
// flop based FIFO with valid/ready on both sides
// ---------------------------------------------------------------
module rx_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  wire              push;
  wire              pop;

  // honest full and empty from the fill count
  assign in_ready  = (count_r != (AW+1)'(DEPTH)); // full only at DEPTH words
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage, written only on a push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count; an empty pop moves nothing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r  <= (AW+1)'(count_r + push - pop);
    end
  end
endmodule

// ---------------------------------------------------------------
// device end of the receive link
// ---------------------------------------------------------------
module pos_rx_device
  import pos_rx_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  pos_rx_if.device_mp            lnk,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_sop,
  input  wire logic              wr_eop,
  input  wire logic              wr_err,
  input  wire logic [PAD_W-1:0]  wr_pad,
  input  wire logic              packet_mode,
  input  wire logic              port_selected,
  input  wire logic              valid_boundary_pause_cfg,
  input  wire logic              parity_odd_cfg
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic              clk_s1_r;
  logic              clk_s2_r;
  logic              clk_s3_r;
  logic              ren_s1_r;
  logic              ren_s2_r;
  logic              pause_r;
  logic [DATA_W-1:0] data_r;
  logic              valid_r;
  logic              sop_r;
  logic              eop_r;
  logic              err_r;
  logic [PAD_W-1:0]  pad_r;
  logic              parity_r;
  logic              oe_r;

  logic              fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic [WORD_W-1:0] fifo_in_data;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire              link_rise;
  wire              take_word;
  wire              empty_read;
  wire              f_sop;
  wire              f_eop;
  wire              f_err;
  wire [PAD_W-1:0]  f_pad;
  wire [DATA_W-1:0] f_data;
  wire              drive_en;

  // one tick per link rising edge, seen after two sync flops
  assign link_rise  = clk_s2_r & ~clk_s3_r;
  // one enabled link cycle asks for one word, none during a pause
  assign take_word  = link_rise & ren_s2_r & ~pause_r & fifo_out_valid;
  assign empty_read = link_rise & ren_s2_r & ~pause_r & ~fifo_out_valid;
  assign f_data     = fifo_out_data[DATA_LSB +: DATA_W];
  assign f_pad      = fifo_out_data[PAD_LSB +: PAD_W];
  assign f_sop      = fifo_out_data[SOP_BIT];
  assign f_eop      = fifo_out_data[EOP_BIT];
  assign f_err      = fifo_out_data[ERR_BIT];
  assign fifo_in_data = {wr_err, wr_eop, wr_sop, wr_pad, wr_data};
  // every output, valid included, uses the same enable
  assign drive_en   = packet_mode & port_selected;

  // ---------------------------------------------------------------
  // receive buffer
  // ---------------------------------------------------------------
  rx_word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (PTR_W)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (take_word),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // link input synchronisers
  // ---------------------------------------------------------------
  // clock and read enable pass two flops before use
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      ren_s1_r <= 1'b0;
      ren_s2_r <= 1'b0;
    end else begin
      clk_s1_r <= lnk.rx_interface_clock;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      ren_s1_r <= lnk.rx_read_enable;
      ren_s2_r <= ren_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // packet boundary pause
  // ---------------------------------------------------------------
  // set after the last word when pausing is configured, left
  // once the far end shows read enable low at a link edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pause_r <= 1'b0;
    end else if (take_word & f_eop & valid_boundary_pause_cfg) begin
      pause_r <= 1'b1;
    end else if (link_rise & ~ren_s2_r) begin
      pause_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // word and flag outputs, changed only on a link rising edge
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      data_r  <= DATA_RST;
      valid_r <= 1'b0;
      sop_r   <= 1'b0;
      eop_r   <= 1'b0;
      err_r   <= 1'b0;
      pad_r   <= PAD_ZERO;
    end else if (take_word) begin
      data_r  <= f_data;
      valid_r <= 1'b1;
      sop_r   <= f_sop;
      eop_r   <= f_eop;
      err_r   <= f_err & f_eop;
      pad_r   <= f_eop ? f_pad : PAD_ZERO;
    end else if (empty_read) begin
      valid_r <= 1'b0;
      eop_r   <= 1'b0;             // empty shows end low
      err_r   <= 1'b0;
      sop_r   <= 1'b0;
      pad_r   <= PAD_ZERO;
    end else if (link_rise) begin
      valid_r <= 1'b0;
      eop_r   <= eop_r & pause_r;  // pause keeps end high
      err_r   <= err_r & pause_r;
      sop_r   <= 1'b0;
      pad_r   <= pause_r ? pad_r : PAD_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // parity and drive enable
  // ---------------------------------------------------------------
  // parity follows the data register, whatever the valid strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      parity_r <= 1'b0;
      oe_r     <= 1'b0;
    end else begin
      parity_r <= (^data_r) ^ parity_odd_cfg;
      oe_r     <= drive_en;
    end
  end

  // ---------------------------------------------------------------
  // link outputs
  // ---------------------------------------------------------------
  assign lnk.rx_word_bus        = data_r;
  assign lnk.rx_word_valid      = valid_r;
  assign lnk.rx_start_of_packet = sop_r;
  assign lnk.rx_end_of_packet   = eop_r;
  assign lnk.rx_packet_error    = err_r;
  assign lnk.rx_pad_byte_count  = pad_r;
  assign lnk.rx_word_parity     = parity_r;
  assign lnk.rx_drive_oe        = oe_r;

endmodule

// file: pos_rx_host.sv
/*
  Holds the link layer end: it makes the link clock by dividing ref_clk,
  drives read enable and collects valid words for its user.
  Assumes the device end answers within a half link period.
*/
module pos_rx_host
  import pos_rx_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    rstn,
  pos_rx_if.host_mp    lnk,
  input  wire logic    read_request,
  output logic         got_word,
  output logic [DATA_W-1:0] got_data,
  output logic         got_sop,
  output logic         got_eop,
  output logic         got_err,
  output logic [PAD_W-1:0] got_pad,
  output logic         got_parity,
  output logic         boundary_pause
);
  logic [DIV_W-1:0]  div_r;
  logic              lclk_r;
  logic              ren_r;
  logic              ren_seen_r;
  logic [1:0]        val_s_r;
  logic [1:0]        eop_s_r;
  logic              oe_s1_r;
  logic              oe_s2_r;

  wire half_done;
  wire rise_tick;
  wire fall_tick;
  wire word_ok;

  assign half_done = (div_r == DIV_W'(LINK_HALF_CYC - 1));
  assign rise_tick = half_done & ~lclk_r;
  assign fall_tick = half_done & lclk_r;
  // outputs count only when the enable was high at the previous edge
  assign word_ok   = rise_tick & ren_seen_r & val_s_r[1] & oe_s2_r;

  // ---------------------------------------------------------------
  // link clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_r  <= '0;
      lclk_r <= 1'b0;
    end else begin
      div_r  <= half_done ? '0 : DIV_W'(div_r + 1'b1);
      lclk_r <= half_done ? ~lclk_r : lclk_r;
    end
  end

  // valid, end flag and drive enable pass two flops; data and the other flags are stable by then
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      val_s_r <= '0;
      eop_s_r <= '0;
      oe_s1_r <= 1'b0;
      oe_s2_r <= 1'b0;
    end else begin
      val_s_r <= {val_s_r[0], lnk.rx_word_valid};
      eop_s_r <= {eop_s_r[0], lnk.rx_end_of_packet};
      oe_s1_r <= lnk.rx_drive_oe;
      oe_s2_r <= oe_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // read enable: changed on the falling half, dropped after a pause
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ren_r          <= 1'b0;
      ren_seen_r     <= 1'b0;
      boundary_pause <= 1'b0;
    end else begin
      if (rise_tick) begin
        ren_seen_r <= ren_r;
      end
      if (rise_tick & ren_seen_r & ~val_s_r[1] & eop_s_r[1]) begin
        boundary_pause <= 1'b1;
      end else if (rise_tick & ~ren_r) begin
        boundary_pause <= 1'b0;
      end
      if (fall_tick) begin
        ren_r <= read_request & ~boundary_pause;
      end
    end
  end

  // ---------------------------------------------------------------
  // user side capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      got_word   <= 1'b0;
      got_data   <= DATA_RST;
      got_sop    <= 1'b0;
      got_eop    <= 1'b0;
      got_err    <= 1'b0;
      got_pad    <= PAD_ZERO;
      got_parity <= 1'b0;
    end else begin
      got_word <= word_ok;
      if (word_ok) begin
        got_data   <= lnk.rx_word_bus;
        got_sop    <= lnk.rx_start_of_packet;
        got_eop    <= lnk.rx_end_of_packet;
        got_err    <= lnk.rx_packet_error;
        got_pad    <= lnk.rx_pad_byte_count;
        got_parity <= lnk.rx_word_parity;
      end
    end
  end

  assign lnk.rx_interface_clock = lclk_r;
  assign lnk.rx_read_enable     = ren_r;
endmodule

// file: pos_receive_valid_control_assertions.sv
/*
  Checker of the packet receive link: watches the interface signals only.
  Assumes the testbench instantiates it beside the interface, without bind.
*/
module pos_receive_valid_control_assertions
  import pos_rx_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic              rx_interface_clock,
  input wire logic              rx_read_enable,
  input wire logic [DATA_W-1:0] rx_word_bus,
  input wire logic              rx_word_valid,
  input wire logic              rx_start_of_packet,
  input wire logic              rx_end_of_packet,
  input wire logic              rx_packet_error,
  input wire logic [PAD_W-1:0]  rx_pad_byte_count,
  input wire logic              rx_word_parity,
  input wire logic              rx_drive_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // link rise tracker
  // ---------------------------------------------------------------
  logic       lclk_d_r;
  logic [5:0] since_rise_r;
  wire        lclk_rise = rx_interface_clock & ~lclk_d_r;

  // counts ref cycles since the sampled link rising edge, saturating
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lclk_d_r     <= 1'b0;
      since_rise_r <= 6'h3f;
    end else begin
      lclk_d_r     <= rx_interface_clock;
      since_rise_r <= lclk_rise ? 6'h00 : ((since_rise_r == 6'h3f) ? since_rise_r : since_rise_r + 6'h01);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_valid_edge_timed: assert property ($changed(rx_word_valid) |-> since_rise_r inside {[6'h01:6'h08]})
    else $error("valid strobe changed away from a link rising edge");
  a_bus_one_pop: assert property ($changed(rx_word_bus) |=> $stable(rx_word_bus)[*8])
    else $error("data bus changed twice within one link cycle");
  a_valid_with_drive: assert property (rx_word_valid |-> rx_drive_oe)
    else $error("valid strobe high while outputs not driven");
  a_err_on_eop: assert property (rx_packet_error |-> rx_end_of_packet)
    else $error("error flag without end flag");
  a_pad_zero_mid: assert property (!rx_end_of_packet |-> rx_pad_byte_count == PAD_ZERO)
    else $error("pad count nonzero without end flag");
  a_underflow_quiet: assert property (!rx_word_valid && !rx_end_of_packet |-> !rx_start_of_packet && !rx_packet_error)
    else $error("flags raised on an empty read");
  a_pause_holds_eop: assert property ($fell(rx_word_valid) && rx_end_of_packet |-> (!rx_word_valid && rx_end_of_packet)[*8])
    else $error("boundary pause not held with end flag");
  a_pause_drops_enable: assert property ($fell(rx_word_valid) && rx_end_of_packet |-> ##[1:80] !rx_read_enable)
    else $error("read enable not dropped after boundary pause");
  a_parity_tracks: assert property (rx_drive_oe && $past(rx_drive_oe) && $past(rx_drive_oe, 2)
      |-> (rx_word_parity ^ $past(rx_word_parity)) == ((^$past(rx_word_bus)) ^ (^$past(rx_word_bus, 2))))
    else $error("parity does not follow the data bus");
endmodule

// file: pos_receive_valid_control_tb.sv
/*
  Testbench of the receive link: device and host ends joined by the interface.
  Assumes the package, interface, both ends and the checker compile first.
*/
module pos_receive_valid_control_tb
  import pos_rx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                ref_clk, rstn, wr_valid, wr_ready, wr_sop, wr_eop, wr_err;
  logic                packet_mode, port_selected, valid_boundary_pause_cfg, parity_odd_cfg;
  logic                read_request, got_word, got_sop, got_eop, got_err, got_parity, boundary_pause;
  logic [DATA_W-1:0]   wr_data, got_data;
  logic [PAD_W-1:0]    wr_pad, got_pad;
  logic [31:0]         rnd;
  logic [WORD_W-1:0]   sb_w;
  logic [WORD_W-1:0]   exp_q[$];
  logic                full_seen = 1'b0;
  logic                bp_d = 1'b0;
  int                  failures = 0;
  int                  n_checks = 0;
  int                  pauses = 0;

  pos_rx_if pos_rx_if_i ();
  pos_rx_device pos_rx_device_i (.ref_clk(ref_clk), .rstn(rstn), .lnk(pos_rx_if_i.device_mp),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .wr_sop(wr_sop), .wr_eop(wr_eop),
    .wr_err(wr_err), .wr_pad(wr_pad), .packet_mode(packet_mode), .port_selected(port_selected),
    .valid_boundary_pause_cfg(valid_boundary_pause_cfg), .parity_odd_cfg(parity_odd_cfg));
  pos_rx_host pos_rx_host_i (.ref_clk(ref_clk), .rstn(rstn), .lnk(pos_rx_if_i.host_mp),
    .read_request(read_request), .got_word(got_word), .got_data(got_data), .got_sop(got_sop),
    .got_eop(got_eop), .got_err(got_err), .got_pad(got_pad), .got_parity(got_parity),
    .boundary_pause(boundary_pause));
  pos_receive_valid_control_assertions assertions_i (.ref_clk(ref_clk), .rstn(rstn),
    .rx_interface_clock(pos_rx_if_i.rx_interface_clock), .rx_read_enable(pos_rx_if_i.rx_read_enable),
    .rx_word_bus(pos_rx_if_i.rx_word_bus), .rx_word_valid(pos_rx_if_i.rx_word_valid),
    .rx_start_of_packet(pos_rx_if_i.rx_start_of_packet), .rx_end_of_packet(pos_rx_if_i.rx_end_of_packet),
    .rx_packet_error(pos_rx_if_i.rx_packet_error), .rx_pad_byte_count(pos_rx_if_i.rx_pad_byte_count),
    .rx_word_parity(pos_rx_if_i.rx_word_parity), .rx_drive_oe(pos_rx_if_i.rx_drive_oe));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // word as the host must see it: error and pad only on the end word
  function automatic logic [WORD_W-1:0] exp_word(input logic [DATA_W-1:0] d, input logic s, e, r,
                                                 input logic [PAD_W-1:0] p);
    return {r & e, e, s, e ? p : PAD_ZERO, d};
  endfunction

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_vec(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d failures %0d", name, n_checks, failures);
  endtask

  // one packet of random words, each held until the FIFO takes it
  task automatic send_pkt(input int len);
    for (int i = 0; i < len; i++) begin
      @(negedge ref_clk);
      rnd = lfsr_next(rnd);
      wr_valid = 1'b1;
      wr_data = rnd;
      wr_sop = (i == 0);
      wr_eop = (i == len - 1);
      wr_err = rnd[3];
      wr_pad = rnd[7:5];
      @(posedge ref_clk);
      for (int k = 0; k < 400 && !wr_ready; k++) @(posedge ref_clk);
    end
    @(negedge ref_clk);
    wr_valid = 1'b0;
  endtask

  // first packet is a single word, then random lengths 1 to 4
  task automatic run_pkts(input int n);
    for (int p = 0; p < n; p++) begin
      rnd = lfsr_next(rnd);
      send_pkt((p == 0) ? 1 : int'(rnd[1:0]) + 1);
    end
  endtask

  task automatic drain();
    for (int k = 0; k < 6000 && exp_q.size() != 0; k++) @(posedge ref_clk);
    cmp_bit("fifo drained", 1'b1, exp_q.size() == 0);
  endtask

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // records accepted writes, refusals and boundary pauses
  always @(posedge ref_clk) begin
    if (wr_valid && wr_ready) exp_q.push_back(exp_word(wr_data, wr_sop, wr_eop, wr_err, wr_pad));
    if (wr_valid && !wr_ready) full_seen = 1'b1;
    if (boundary_pause && !bp_d) pauses++;
    bp_d <= boundary_pause;
  end

  // compares every word the host accepts against the write order
  always @(posedge ref_clk) begin
    if (got_word === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp_bit("unexpected word", 1'b0, got_word);
      end else begin
        sb_w = exp_q.pop_front();
        cmp_vec("data", sb_w[DATA_W-1:0], got_data);
        cmp_bit("start", sb_w[SOP_BIT], got_sop);
        cmp_bit("end", sb_w[EOP_BIT], got_eop);
        cmp_bit("error", sb_w[ERR_BIT], got_err);
        cmp_vec("pad", DATA_W'(sb_w[SOP_BIT-1:PAD_LSB]), DATA_W'(got_pad));
        cmp_bit("parity", (^sb_w[DATA_W-1:0]) ^ parity_odd_cfg, got_parity);
      end
    end
  end

  // watchdog
  initial begin
    #200_000;
    failures++;
    final_report();
  end

  // main sequence
  initial begin
    rnd = 32'h0000_5bac;
    {rstn, wr_valid, wr_sop, wr_eop, wr_err, read_request, valid_boundary_pause_cfg, parity_odd_cfg} = '0;
    wr_data = '0;
    wr_pad = '0;
    packet_mode = 1'b1;
    port_selected = 1'b1;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    // occupancy mode, back to back words, FIFO fills and refuses
    read_request = 1'b1;
    run_pkts(6);
    drain();
    cmp_bit("fifo refused when full", 1'b1, full_seen);
    end_test("occupancy");
    // reads of an empty FIFO deliver nothing, then resume
    repeat (400) @(posedge ref_clk);
    run_pkts(2);
    drain();
    end_test("underflow");
    // boundary pause mode
    @(negedge ref_clk);
    read_request = 1'b0;
    repeat (80) @(negedge ref_clk);
    valid_boundary_pause_cfg = 1'b1;
    pauses = 0;
    read_request = 1'b1;
    run_pkts(5);
    drain();
    cmp_bit("pause per boundary", 1'b1, pauses >= 4);
    end_test("pause");
    // drive enable in cell mode and deselection
    @(negedge ref_clk);
    read_request = 1'b0;
    valid_boundary_pause_cfg = 1'b0;
    repeat (80) @(negedge ref_clk);
    packet_mode = 1'b0;
    repeat (3) @(negedge ref_clk);
    cmp_bit("drive in cell mode", 1'b0, pos_rx_if_i.rx_drive_oe);
    packet_mode = 1'b1;
    port_selected = 1'b0;
    parity_odd_cfg = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp_bit("drive when deselected", 1'b0, pos_rx_if_i.rx_drive_oe);
    port_selected = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp_bit("drive when selected", 1'b1, pos_rx_if_i.rx_drive_oe);
    read_request = 1'b1;
    run_pkts(3);
    drain();
    end_test("drive");
    final_report();
  end
endmodule
